// *** src/dsl_top.sv ***
// What this block does
// - sixteen falling clock edges shift one word
// - frame high ignores clock and data
// - long frame yields successive sixteen-bit words
// - any serial clock idle level works
// - reset bit clears accumulator to zero
// - reset bit keeps frequency, phase, control
// - first sample seven cycles after release
// - register change reaches output six (phase) or seven (frequency) cycles
// - reset, frequency select and phase select control bits sampled on falling master edge
// - top bits zero mean control write
// - full-word mode: low then high writes
// - full-word update only after second word
// - half mode updates chosen half only
// - half select one means upper bits
// - frequency select picks accumulator step
// - control bit eight is reset
// - 28-bit accumulator adds step each cycle
module dsl_top
    import dsl_pkg::*;
#(
    parameter int PIPE_STAGES = PIPE_DEPTH
)
(
    // master clock and reset
    input  wire logic               mclk,
    input  wire logic               rst,
    // serial link
    input  wire logic               sclk,
    input  wire logic               frame_sync_n,
    input  wire logic               sdata,
    // oscillator output
    output logic [PHASE_W-1:0]      phase_word_r,
    output logic                    sample_valid_r,
    output logic                    waveform_mode_r
);
    // *****************************************
    // parameter check
    // *****************************************
    if (PIPE_STAGES < 1) begin : g_bad_depth
        $error("PIPE_STAGES must be at least one");
    end

    // *****************************************
    // link capture and crossing
    // *****************************************
    logic [WORD_W-1:0] hold;
    logic              done_tgl;
    dsl_word_if        wbus ();

    dsl_shift u_shift (
        .sclk         (sclk),
        .frame_sync_n (frame_sync_n),
        .sdata        (sdata),
        .rst          (rst),
        .hold_r       (hold),
        .done_tgl_r   (done_tgl)
    );

    dsl_sync u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .hold     (hold),
        .done_tgl (done_tgl),
        .wout     (wbus)
    );

    // *****************************************
    // word decode
    // *****************************************
    wire [1:0]        addr      = wbus.word[ADDR_HI:ADDR_LO];
    wire [HALF_W-1:0] payload   = wbus.word[HALF_W-1:0];
    wire              wr_ctrl   = wbus.strobe && (addr == ADDR_CTRL);
    wire              wr_fa     = wbus.strobe && (addr == ADDR_FREQ_A);
    wire              wr_fb     = wbus.strobe && (addr == ADDR_FREQ_B);
    wire              wr_ph     = wbus.strobe && (addr == ADDR_PHASE);
    wire              wr_freq   = wr_fa || wr_fb;

    logic [15:0]      ctrl_r;
    logic [ACC_W-1:0] freq_a_r;
    logic [ACC_W-1:0] freq_b_r;
    logic [PHASE_W-1:0] phase0_r;
    logic [PHASE_W-1:0] phase1_r;
    logic             pending_r;
    logic [HALF_W-1:0] low_hold_r;

    wire full_word  = ctrl_r[FULL_WORD_BIT];
    wire half_upper = ctrl_r[HALF_UP_BIT];
    wire second     = full_word && pending_r;

    // new value for an addressed frequency register
    // every input is an argument so the assigns below track all of them
    function automatic logic [ACC_W-1:0] freq_upd(
        input logic [ACC_W-1:0]  old,
        input logic [HALF_W-1:0] pay,
        input logic [HALF_W-1:0] low,
        input logic              fw,
        input logic              hu
    );
        if (fw)
            freq_upd = {pay, low};
        else if (hu)
            freq_upd = {pay, old[HALF_W-1:0]};
        else
            freq_upd = {old[ACC_W-1:HALF_W], pay};
    endfunction

    wire commit    = wr_freq && (!full_word || second);
    wire [ACC_W-1:0] fa_nxt = freq_upd(freq_a_r, payload, low_hold_r, full_word, half_upper);
    wire [ACC_W-1:0] fb_nxt = freq_upd(freq_b_r, payload, low_hold_r, full_word, half_upper);

    // *****************************************
    // register file
    // *****************************************
    always_ff @(posedge mclk) begin
        if (rst)
            ctrl_r <= CTRL_RST_VAL;
        else if (wr_ctrl)
            ctrl_r <= {2'h0, payload};
    end

    // reset bit has no effect here: only writes and rst change them
    always_ff @(posedge mclk) begin
        if (rst) begin
            freq_a_r <= '0;
            freq_b_r <= '0;
        end else if (commit) begin
            if (wr_fa)
                freq_a_r <= fa_nxt;
            if (wr_fb)
                freq_b_r <= fb_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            phase0_r <= '0;
            phase1_r <= '0;
        end else if (wr_ph) begin
            if (wbus.word[PHASE_SEL_BIT])
                phase1_r <= payload[PHASE_W-1:0];
            else
                phase0_r <= payload[PHASE_W-1:0];
        end
    end

    // first half of a full-word pair
    always_ff @(posedge mclk) begin
        if (rst || wr_ctrl) begin
            pending_r  <= 1'b0;
            low_hold_r <= '0;
        end else if (wr_freq && full_word) begin
            pending_r <= ~pending_r;
            if (!pending_r)
                low_hold_r <= payload;
        end
    end

    // *****************************************
    // falling edge control sampling
    // *****************************************
    logic reset_s_r;
    logic fsel_s_r;
    logic psel_s_r;

    always_ff @(negedge mclk) begin
        if (rst) begin
            reset_s_r <= 1'b1;
            fsel_s_r  <= 1'b0;
            psel_s_r  <= 1'b0;
        end else begin
            reset_s_r <= ctrl_r[RESET_BIT];
            fsel_s_r  <= ctrl_r[FSEL_BIT];
            psel_s_r  <= ctrl_r[PSEL_BIT];
        end
    end

    // *****************************************
    // numeric oscillator
    // *****************************************
    logic [ACC_W-1:0] acc_r;
    logic             live_r;
    wire  [ACC_W-1:0] step      = fsel_s_r ? freq_b_r : freq_a_r;
    wire  [ACC_W-1:0] acc_nxt   = ACC_W'(acc_r + step);
    wire  [PHASE_W-1:0] offset  = psel_s_r ? phase1_r : phase0_r;
    wire  [PHASE_W-1:0] phase_now = PHASE_W'(acc_r[ACC_W-1 -: PHASE_W] + offset);

    always_ff @(posedge mclk) begin
        if (rst || reset_s_r) begin
            acc_r  <= '0;
            live_r <= 1'b0;
        end else begin
            acc_r  <= acc_nxt;
            live_r <= 1'b1;
        end
    end

    // *****************************************
    // output latency line
    // *****************************************
    logic [PHASE_W-1:0] pipe_ph_r [PIPE_STAGES];
    // unpacked so each stage is a variable of its own process
    logic               pipe_v_r  [PIPE_STAGES];

    for (genvar i = 0; i < PIPE_STAGES; i++) begin : g_pipe
        always_ff @(posedge mclk) begin
            if (rst) begin
                pipe_ph_r[i] <= '0;
                pipe_v_r[i]  <= 1'b0;
            end else if (i == 0) begin
                pipe_ph_r[i] <= phase_now;
                pipe_v_r[i]  <= live_r;
            end else begin
                pipe_ph_r[i] <= pipe_ph_r[(i == 0) ? 0 : i-1];
                pipe_v_r[i]  <= pipe_v_r[(i == 0) ? 0 : i-1];
            end
        end
    end

    assign phase_word_r   = pipe_ph_r[PIPE_STAGES-1];
    assign sample_valid_r = pipe_v_r[PIPE_STAGES-1];

    // mode bit bypasses falling-edge sampling
    always_ff @(posedge mclk) begin
        if (rst)
            waveform_mode_r <= 1'b0;
        else
            waveform_mode_r <= ctrl_r[MODE_BIT];
    end

    // *****************************************
    // checks
    // *****************************************
    AST_ACC_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        reset_s_r |=> acc_r == '0)
        else $error("accumulator not cleared under reset bit");

    AST_CTRL_DECODE: assert property (@(posedge mclk) disable iff (rst)
        wr_ctrl |=> ctrl_r == {2'h0, $past(wbus.word[HALF_W-1:0])})
        else $error("control write not decoded");

    AST_ROUTE_DATA: assert property (@(posedge mclk) disable iff (rst)
        wbus.strobe && addr != ADDR_CTRL |=> $stable(ctrl_r))
        else $error("data word reached control register");

    AST_PAIR_HOLD: assert property (@(posedge mclk) disable iff (rst)
        wr_freq && full_word && !pending_r |=> $stable(freq_a_r) && $stable(freq_b_r))
        else $error("frequency changed after first half");

    AST_PAIR_DONE: assert property (@(posedge mclk) disable iff (rst)
        wr_fa && second |=> freq_a_r == {$past(payload), $past(low_hold_r)})
        else $error("full word not assembled low then high");

    AST_HALF_UPPER: assert property (@(posedge mclk) disable iff (rst)
        wr_fa && !full_word && half_upper |=>
        freq_a_r[ACC_W-1:HALF_W] == $past(payload) &&
        freq_a_r[HALF_W-1:0] == $past(freq_a_r[HALF_W-1:0]))
        else $error("upper half write wrong");

    AST_KEEP_REGS: assert property (@(posedge mclk) disable iff (rst)
        !wbus.strobe |=> $stable(freq_a_r) && $stable(phase0_r) && $stable(ctrl_r))
        else $error("register changed without a write");

    AST_NEG_SAMPLE: assert property (@(posedge mclk) disable iff (rst || $past(rst))
        reset_s_r == ctrl_r[RESET_BIT] && fsel_s_r == ctrl_r[FSEL_BIT])
        else $error("control not sampled on falling edge");

    AST_ACC_STEP: assert property (@(posedge mclk) disable iff (rst)
        !reset_s_r && !$past(reset_s_r) |->
        acc_r == ACC_W'($past(acc_r) + ($past(fsel_s_r) ? $past(freq_b_r)
                                                        : $past(freq_a_r))))
        else $error("accumulator step wrong");

    AST_START_LAT: assert property (@(posedge mclk) disable iff (rst)
        $fell(ctrl_r[RESET_BIT]) |-> ##7 sample_valid_r)
        else $error("first sample not seven cycles after release");

    AST_OUT_LAT: assert property (@(posedge mclk) disable iff (rst)
        sample_valid_r |-> phase_word_r == $past(phase_now, 6))
        else $error("output latency wrong");

    COV_CTRL: cover property (@(posedge mclk) wr_ctrl);
    COV_PAIR: cover property (@(posedge mclk) wr_freq && second);
    COV_HALF: cover property (@(posedge mclk) wr_freq && !full_word);
    COV_START: cover property (@(posedge mclk) $rose(sample_valid_r));
endmodule

// *** src/dsl_pkg.sv ***
package dsl_pkg;
    // *****************************************
    // serial word layout
    // *****************************************
    localparam int          WORD_W        = 16;
    localparam int          CNT_W         = 4;
    localparam logic [3:0]  LAST_BIT      = 4'h000F;
    localparam int          ADDR_HI       = 15;
    localparam int          ADDR_LO       = 14;
    localparam logic [1:0]  ADDR_CTRL     = 2'h0;
    localparam logic [1:0]  ADDR_FREQ_A   = 2'h1;
    localparam logic [1:0]  ADDR_FREQ_B   = 2'h2;
    localparam logic [1:0]  ADDR_PHASE    = 2'h3;
    localparam int          HALF_W        = 14;
    localparam int          PHASE_SEL_BIT = 13;
    // *****************************************
    // control word fields
    // *****************************************
    localparam int          FULL_WORD_BIT = 13;
    localparam int          HALF_UP_BIT   = 12;
    localparam int          FSEL_BIT      = 11;
    localparam int          PSEL_BIT      = 10;
    localparam int          RESET_BIT     = 8;
    localparam int          MODE_BIT      = 1;
    localparam logic [15:0] CTRL_RST_VAL  = 16'h0100;
    // *****************************************
    // datapath and timing
    // *****************************************
    localparam int          ACC_W         = 28;
    localparam int          PHASE_W       = 12;
    localparam int          MCLK_PERIOD_NS = 10;
    localparam int          START_LAT_CYC = 7;
    localparam int          PIPE_DEPTH    = START_LAT_CYC - 1;
    localparam int          SYNC_STAGES   = 3;
endpackage

// *** src/dsl_word_if.sv ***
interface dsl_word_if;
    logic [15:0] word;
    logic        strobe;
    modport producer (output word, output strobe);
    modport consumer (input word, input strobe);
endinterface

// *** src/dsl_shift.sv ***
module dsl_shift
    import dsl_pkg::*;
(
    // link
    input  wire logic              sclk,
    input  wire logic              frame_sync_n,
    input  wire logic              sdata,
    // reset, constant load only
    input  wire logic              rst,
    // completed word
    output logic [WORD_W-1:0]      hold_r,
    output logic                   done_tgl_r
);
    logic [CNT_W-1:0]  cnt_r;
    logic [WORD_W-2:0] sr_r;
    wire  [WORD_W-1:0] word_nxt = {sr_r, sdata};
    wire               last     = (cnt_r == LAST_BIT);

    // frame high clears the count, drops a partial word
    always_ff @(negedge sclk or posedge frame_sync_n) begin
        if (frame_sync_n) begin
            cnt_r <= '0;
            sr_r  <= '0;
        end else begin
            cnt_r <= cnt_r + 4'h0001;
            sr_r  <= word_nxt[WORD_W-2:0];
        end
    end

    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            hold_r     <= '0;
            done_tgl_r <= 1'b0;
        end else if (!frame_sync_n && last) begin
            hold_r     <= word_nxt;
            done_tgl_r <= ~done_tgl_r;
        end
    end

    AST_WORD_DONE: assert property (@(negedge sclk) disable iff (frame_sync_n || rst)
        last |=> done_tgl_r != $past(done_tgl_r))
        else $error("word not completed at sixteenth edge");
endmodule

// *** src/dsl_sync.sv ***
module dsl_sync
    import dsl_pkg::*;
(
    // master clock
    input  wire logic              mclk,
    input  wire logic              rst,
    // from link domain
    input  wire logic [WORD_W-1:0] hold,
    input  wire logic              done_tgl,
    // to decoder
    dsl_word_if.producer           wout
);
    logic [SYNC_STAGES-1:0] sync_r;
    logic                   seen_r;
    logic [WORD_W-1:0]      word_r;
    logic                   strobe_r;
    wire                    agree = (sync_r[1] == sync_r[2]);
    wire                    fresh = agree && (sync_r[2] != seen_r);

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_r   <= '0;
            seen_r   <= 1'b0;
            word_r   <= '0;
            strobe_r <= 1'b0;
        end else begin
            sync_r   <= {sync_r[1:0], done_tgl};
            strobe_r <= fresh;
            if (fresh) begin
                seen_r <= sync_r[2];
                word_r <= hold;
            end
        end
    end

    assign wout.word   = word_r;
    assign wout.strobe = strobe_r;
endmodule

// *** test/dsl_host_model.sv ***
module dsl_host_model (
    // link pins
    output logic sclk,
    output logic frame_sync_n,
    output logic sdata
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int HALF_NS = 80;
    realtime       last_fall_t;

    initial begin
        sclk = 1'b1;
        frame_sync_n = 1'b1;
        sdata = 1'b0;
        last_fall_t = 0.0;
    end

    // released data line keeps changing so stale bits never look valid
    always #HALF_NS begin
        if (frame_sync_n) sdata = ~sdata;
    end

    // *****************************************
    // frame of back to back words, msb first
    // *****************************************
    task automatic send(input logic [15:0] ws[$], input logic idle, input int nbits);
        int i;
        sclk = idle;
        #23;
        frame_sync_n = 1'b0;
        for (i = 0; i < nbits; i++) begin
            sclk = 1'b1;
            sdata = ws[i / 16][15 - (i % 16)];
            #HALF_NS;
            sclk = 1'b0;
            last_fall_t = $realtime;
            #HALF_NS;
        end
        sclk = idle;
        #HALF_NS;
        frame_sync_n = 1'b1;
    endtask

    // clock edges with frame high, to be ignored
    task automatic noise(input int n);
        repeat (2 * n) begin
            sclk = ~sclk;
            #HALF_NS;
        end
    endtask
endmodule

// *** test/tb.sv ***
module tb
    import dsl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic               mclk;
    logic               rst;
    logic               sclk;
    logic               frame_sync_n;
    logic               sdata;
    logic [PHASE_W-1:0] phase_word_r;
    logic               sample_valid_r;
    logic               waveform_mode_r;
    logic [PHASE_W-1:0] exp_q[$];
    logic [PHASE_W-1:0] prev_phase;
    logic               prev_valid;
    logic [11:0]        k2;
    logic [11:0]        k3;
    realtime            t_rise;
    int                 error_cnt;
    int                 cmp_count;
    int                 seed;

    dsl_top #(.PIPE_STAGES(PIPE_DEPTH)) dut (
        .mclk(mclk), .rst(rst), .sclk(sclk), .frame_sync_n(frame_sync_n), .sdata(sdata),
        .phase_word_r(phase_word_r), .sample_valid_r(sample_valid_r),
        .waveform_mode_r(waveform_mode_r)
    );

    dsl_host_model host (.sclk(sclk), .frame_sync_n(frame_sync_n), .sdata(sdata));

    always #(MCLK_PERIOD_NS / 2.0) mclk = ~mclk;

    // *****************************************
    // helpers
    // *****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [15:0] fhi(input logic [1:0] a, input logic [11:0] k);
        return {a, k, 2'b00};
    endfunction

    task automatic wr(input logic [15:0] ws[$], input logic idle);
        host.send(ws, idle, 16 * ws.size());
        repeat (10) @(posedge mclk);
        #1;
    endtask

    // accumulator step seen at the output, step word = k << 16
    task automatic expect_steps(input logic [11:0] k);
        int n;
        repeat (4) exp_q.push_back(k);
        for (n = 0; n < 200 && exp_q.size() > 0; n++) @(posedge mclk);
        #1;
        check("step queue drained", 32'(exp_q.size()), 32'd0);
    endtask

    task automatic check_start();
        int cyc;
        cyc = int'((t_rise - host.last_fall_t) / MCLK_PERIOD_NS);
        check("start latency in range", 32'(cyc >= 12 && cyc <= 13), 32'd1);
    endtask

    // *****************************************
    // output monitor
    // *****************************************
    always @(posedge mclk) begin
        if (prev_valid === 1'b1 && sample_valid_r === 1'b1 && exp_q.size() > 0)
            check("phase step", 32'(12'(phase_word_r - prev_phase)), 32'(exp_q.pop_front()));
        if (prev_valid === 1'b0 && sample_valid_r === 1'b1) t_rise = $realtime;
        prev_phase <= phase_word_r;
        prev_valid <= sample_valid_r;
    end

    initial begin
        #500_000;
        error_cnt++;
        final_report();
    end

    // *****************************************
    // main sequence
    // *****************************************
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        error_cnt = 0;
        cmp_count = 0;
        seed = 32'hbe7d_35fa;
        t_rise = 0.0;
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        check("valid after rst", 32'(sample_valid_r), 32'd0);
        check("phase after rst", 32'(phase_word_r), 32'd0);
        check("mode after rst", 32'(waveform_mode_r), 32'd0);
        $display("test reset done");

        wr({16'h2100, 16'h4000, fhi(2'b01, 12'h003), 16'h2002}, 1'b1);
        check("mode set", 32'(waveform_mode_r), 32'd1);
        check_start();
        expect_steps(12'h003);
        $display("test full word load done");

        k2 = 12'($random(seed));
        wr({16'h1802, fhi(2'b10, k2)}, 1'b0);
        expect_steps(k2);
        wr({16'h0802, 16'h8000}, 1'b0);
        expect_steps(k2);
        $display("test half load done");

        host.noise(5);
        host.send({16'hffff}, 1'b1, 8);
        host.noise(3);
        wr({16'h0000}, 1'b1);
        check("mode cleared", 32'(waveform_mode_r), 32'd0);
        expect_steps(12'h003);
        $display("test ignored edges done");

        wr({16'h0100}, 1'b0);
        check("valid under reset bit", 32'(sample_valid_r), 32'd0);
        wr({16'h0000}, 1'b0);
        check_start();
        expect_steps(12'h003);
        $display("test reset bit done");

        wr({16'he005, 16'h0402}, 1'b0);
        check("mode after phase write", 32'(waveform_mode_r), 32'd1);
        expect_steps(12'h003);
        $display("test phase route done");

        k3 = 12'($random(seed));
        wr({16'h2000, 16'h4000}, 1'b1);
        expect_steps(12'h003);
        wr({fhi(2'b01, k3)}, 1'b1);
        expect_steps(k3);
        $display("test running full word done");
        final_report();
    end
endmodule
